// *** rtl/nfc_host.sv ***
// Host controller that drives a parallel NAND flash through its pins.
`timescale 1ns/1ps
`default_nettype none
module nfc_host #(
  parameter int BLK_W = 12,
  parameter int LEN_W = 13
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_cmd_valid,
  input  wire logic [2:0]       i_cmd_op,
  input  wire logic [BLK_W-1:0] i_block,
  input  wire logic [5:0]       i_page,
  input  wire logic [12:0]      i_col,
  input  wire logic [LEN_W-1:0] i_len,
  input  wire logic             i_abort,
  output logic                  o_cmd_ready,
  output logic                  o_done,
  output logic                  o_refused,
  output logic                  o_fail,
  output logic [7:0]            o_status,
  input  wire logic [7:0]       i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic [7:0]            o_rd_data,
  output logic                  o_rd_valid,
  output logic                  o_ecc_unit_end,
  output logic [12:0]           o_bad_count,
  output logic                  o_good_low,
  output logic                  o_ce_n,
  output logic                  o_cle,
  output logic                  o_ale,
  output logic                  o_we_n,
  output logic                  o_re_n,
  output logic                  o_wp_n,
  input  wire logic [7:0]       i_dq,
  output logic [7:0]            o_dq,
  output logic                  o_dq_oe,
  input  wire logic             i_ready_busy_line
);

  // Elaboration checks on parameters and timing.
  if (nfc_pkg::PH_CYC < 3) begin : g_chk_ph
    $error("Strobe phase too short for the input synchroniser");
  end
  if (2 ** BLK_W != nfc_pkg::N_BLOCKS) begin : g_chk_blk
    $error("Block address width does not match the block count");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CLEAR = 4'b0001,
    ST_RSTC  = 4'b0010,
    ST_POLLC = 4'b0011,
    ST_POLLR = 4'b0100,
    ST_CHK   = 4'b0101,
    ST_C1    = 4'b0110,
    ST_ADDR  = 4'b0111,
    ST_WDAT  = 4'b1000,
    ST_C2    = 4'b1001,
    ST_RETC  = 4'b1010,
    ST_RDAT  = 4'b1011,
    ST_STRD  = 4'b1100,
    ST_UPD   = 4'b1101,
    ST_FIN   = 4'b1110
  } nfc_state_t;

  nfc_state_t           state;
  nfc_pkg::nfc_op_t     op;
  logic [BLK_W-1:0]     blk;
  logic [BLK_W-1:0]     clr_idx;
  logic [5:0]           page;
  logic [12:0]          col;
  logic [LEN_W-1:0]     len;
  logic [LEN_W-1:0]     cnt;
  logic [2:0]           addr_i;
  logic                 aborted;
  logic                 poll_wait;
  logic [nfc_pkg::E_W-1:0] ent;
  logic [nfc_pkg::E_W-1:0] tbl_rdata;
  logic [nfc_pkg::E_W-1:0] new_ent;
  logic                 tbl_we;
  logic [BLK_W-1:0]     tbl_waddr;
  logic [7:0]           dq_m;
  logic [7:0]           dq_s;
  logic                 rb_m;
  logic                 rb_s;
  logic [3:0]           div;
  logic                 tick;
  logic                 cyc_act;
  logic                 ph;
  logic [1:0]           kind;
  logic                 cyc_done;
  logic                 want;
  logic [1:0]           want_kind;
  logic [7:0]           want_byte;
  logic [7:0]           addr_byte;
  logic [7:0]           c1_byte;
  logic [7:0]           c2_byte;
  logic [17:0]          row;
  logic [6:0]           e_next;
  logic [1:0]           e_cnt;
  logic                 fail_now;

  assign row    = {blk, page};
  assign e_next = ent[nfc_pkg::E_NEXT_LSB +: 7];
  assign e_cnt  = ent[nfc_pkg::E_CNT_LSB +: 2];
  assign fail_now = o_status[nfc_pkg::ST_FAIL] | aborted;

  // Two-flop synchronisers for the data pins and the busy line.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dq_m <= 8'h00;
      dq_s <= 8'h00;
      rb_m <= 1'b0;
      rb_s <= 1'b0;
    end else begin
      dq_m <= i_dq;
      dq_s <= dq_m;
      rb_m <= i_ready_busy_line;
      rb_s <= rb_m;
    end
  end

  // Divider giving one strobe-phase enable pulse every PH_CYC cycles.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div <= 4'h0;
    end else if (div == 4'(nfc_pkg::PH_CYC - 1)) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end
  assign tick     = (div == 4'h0);
  assign cyc_done = cyc_act & tick & ph;

  // Byte cycle engine: set up lines, strobe low one phase, then high.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_act   <= 1'b0;
      ph        <= 1'b0;
      kind      <= nfc_pkg::K_CMD;
      o_dq      <= 8'h00;
      o_dq_oe   <= 1'b0;
      o_cle     <= 1'b0;
      o_ale     <= 1'b0;
      o_we_n    <= 1'b1;
      o_re_n    <= 1'b1;
    end else if (!cyc_act) begin
      if (want) begin
        cyc_act <= 1'b1;
        kind    <= want_kind;
        o_dq    <= want_byte;
        o_dq_oe <= (want_kind != nfc_pkg::K_RD);
        o_cle   <= (want_kind == nfc_pkg::K_CMD);
        o_ale   <= (want_kind == nfc_pkg::K_ADDR);
      end
    end else if (tick) begin
      if (!ph) begin
        ph     <= 1'b1;
        o_we_n <= (kind == nfc_pkg::K_RD);
        o_re_n <= (kind != nfc_pkg::K_RD);
      end else begin
        ph      <= 1'b0;
        cyc_act <= 1'b0;
        o_we_n  <= 1'b1;
        o_re_n  <= 1'b1;
      end
    end
  end

  // Command bytes per operation, all from the defined set.
  always_comb begin
    c1_byte = nfc_pkg::CMD_STATUS;
    c2_byte = nfc_pkg::CMD_READ2;
    case (op)
      nfc_pkg::OP_READ, nfc_pkg::OP_SCAN: begin
        c1_byte = nfc_pkg::CMD_READ1;
        c2_byte = nfc_pkg::CMD_READ2;
      end
      nfc_pkg::OP_PROG: begin
        c1_byte = nfc_pkg::CMD_DATAIN;
        c2_byte = nfc_pkg::CMD_PROG;
      end
      nfc_pkg::OP_ERASE: begin
        c1_byte = nfc_pkg::CMD_ERASE1;
        c2_byte = nfc_pkg::CMD_ERASE2;
      end
      default: begin
        c1_byte = nfc_pkg::CMD_STATUS;
        c2_byte = nfc_pkg::CMD_READ2;
      end
    endcase
  end

  // Five address bytes, two column and three row, of which erase sends only the three row bytes; a sixth is never sent.
  always_comb begin
    case (addr_i)
      3'd0:    addr_byte = col[7:0];
      3'd1:    addr_byte = {3'b000, col[12:8]};
      3'd2:    addr_byte = row[7:0];
      3'd3:    addr_byte = row[15:8];
      default: addr_byte = {6'b000000, row[17:16]};
    endcase
  end

  // Byte cycle requested by the current state.
  always_comb begin
    want      = 1'b0;
    want_kind = nfc_pkg::K_CMD;
    want_byte = 8'h00;
    case (state)
      ST_RSTC: begin
        want      = 1'b1;
        want_byte = nfc_pkg::CMD_RESET;
      end
      ST_C1: begin
        want      = 1'b1;
        want_byte = c1_byte;
      end
      ST_ADDR: begin
        want      = 1'b1;
        want_kind = nfc_pkg::K_ADDR;
        want_byte = addr_byte;
      end
      ST_WDAT: begin
        want      = i_wr_valid;
        want_kind = nfc_pkg::K_WR;
        want_byte = i_wr_data;
      end
      ST_C2: begin
        want      = 1'b1;
        want_byte = c2_byte;
      end
      ST_POLLC: begin
        want      = 1'b1;
        want_byte = nfc_pkg::CMD_STATUS;
      end
      ST_POLLR: begin
        want      = ~poll_wait | rb_s;
        want_kind = nfc_pkg::K_RD;
      end
      ST_RETC: begin
        want      = 1'b1;
        want_byte = nfc_pkg::CMD_READ1;
      end
      ST_RDAT, ST_STRD: begin
        want      = 1'b1;
        want_kind = nfc_pkg::K_RD;
      end
      default: begin
        want = 1'b0;
      end
    endcase
  end

  // Main sequencer.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state     <= ST_CLEAR;
      op        <= nfc_pkg::OP_RESET;
      blk       <= '0;
      clr_idx   <= '0;
      page      <= 6'h00;
      col       <= 13'h0000;
      len       <= '0;
      cnt       <= '0;
      addr_i    <= 3'd0;
      aborted   <= 1'b0;
      poll_wait <= 1'b0;
      ent       <= '0;
      o_refused <= 1'b0;
      o_fail    <= 1'b0;
      o_status  <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_cmd_valid) begin
            op        <= nfc_pkg::nfc_op_t'(i_cmd_op);
            blk       <= i_block;
            page      <= i_page;
            col       <= i_col;
            len       <= i_len;
            aborted   <= 1'b0;
            o_refused <= 1'b0;
            o_fail    <= 1'b0;
            case (i_cmd_op)
              nfc_pkg::OP_STATUS: state <= ST_C1;
              nfc_pkg::OP_RESET:  state <= ST_RSTC;
              default:            state <= ST_CHK;
            endcase
          end
        end
        ST_CLEAR: begin
          clr_idx <= clr_idx + 1'b1;
          if (&clr_idx) begin
            state <= ST_RSTC;
          end
        end
        ST_CHK: begin
          ent    <= tbl_rdata;
          addr_i <= (op == nfc_pkg::OP_ERASE) ? 3'(nfc_pkg::ROW_FIRST) : 3'd0;
          state  <= ST_C1;
          if (op == nfc_pkg::OP_PROG) begin
            if (tbl_rdata[nfc_pkg::E_BAD]) begin
              o_refused <= 1'b1;
              state     <= ST_FIN;
            end else if ({1'b0, page} == tbl_rdata[nfc_pkg::E_NEXT_LSB +: 7]) begin
              state <= ST_C1;
            end else if ({1'b0, page} + 7'd1 != tbl_rdata[nfc_pkg::E_NEXT_LSB +: 7]
                || tbl_rdata[nfc_pkg::E_CNT_LSB +: 2] == 2'(nfc_pkg::MAX_PARTIAL - 1)) begin
              o_refused <= 1'b1;
              state     <= ST_FIN;
            end
          end else if (op == nfc_pkg::OP_ERASE && tbl_rdata[nfc_pkg::E_BAD]) begin
            o_refused <= 1'b1;
            state     <= ST_FIN;
          end
        end
        ST_C1: begin
          if (cyc_done) begin
            state <= (op == nfc_pkg::OP_STATUS) ? ST_STRD : ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cyc_done) begin
            addr_i <= addr_i + 3'd1;
            cnt    <= '0;
            if (addr_i == 3'(nfc_pkg::ADDR_LAST)) begin
              state <= (op == nfc_pkg::OP_PROG) ? ST_WDAT : ST_C2;
            end
          end
        end
        ST_WDAT: begin
          if (cyc_done) begin
            cnt <= cnt + 1'b1;
            if (cnt == len - 1'b1) begin
              state <= ST_C2;
            end
          end
        end
        ST_C2, ST_RSTC: begin
          if (cyc_done) begin
            poll_wait <= 1'b0;
            state     <= ST_POLLC;
          end
        end
        ST_POLLC, ST_POLLR: begin
          if (i_abort && cyc_done && !aborted
              && (op == nfc_pkg::OP_PROG || op == nfc_pkg::OP_ERASE)) begin
            aborted <= 1'b1;
            state   <= ST_RSTC;
          end else if (cyc_done && state == ST_POLLC) begin
            state <= ST_POLLR;
          end else if (cyc_done) begin
            o_status  <= dq_s;
            poll_wait <= ~dq_s[nfc_pkg::ST_RDY];
            if (dq_s[nfc_pkg::ST_RDY]) begin
              case (op)
                nfc_pkg::OP_READ, nfc_pkg::OP_SCAN: state <= ST_RETC;
                nfc_pkg::OP_PROG, nfc_pkg::OP_ERASE: state <= ST_UPD;
                default: state <= ST_FIN;
              endcase
            end
          end
        end
        ST_RETC: begin
          if (cyc_done) begin
            cnt   <= '0;
            state <= ST_RDAT;
          end
        end
        ST_RDAT: begin
          if (cyc_done) begin
            cnt <= cnt + 1'b1;
            if (cnt == len - 1'b1) begin
              state <= (op == nfc_pkg::OP_SCAN) ? ST_UPD : ST_FIN;
            end
          end
        end
        ST_STRD: begin
          if (cyc_done) begin
            o_status <= dq_s;
            state    <= ST_FIN;
          end
        end
        ST_UPD: begin
          o_fail <= new_ent[nfc_pkg::E_BAD] & (fail_now | op == nfc_pkg::OP_SCAN);
          state  <= ST_FIN;
        end
        ST_FIN: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // New table entry after a program, erase or scan.
  always_comb begin
    new_ent = ent;
    case (op)
      nfc_pkg::OP_SCAN: begin
        new_ent[nfc_pkg::E_BAD] = ent[nfc_pkg::E_BAD] | (o_rd_data == nfc_pkg::BB_MARK);
      end
      nfc_pkg::OP_ERASE: begin
        new_ent = fail_now ? (ent | nfc_pkg::E_W'(1 << nfc_pkg::E_BAD)) : '0;
      end
      nfc_pkg::OP_PROG: begin
        if (fail_now) begin
          new_ent[nfc_pkg::E_BAD] = 1'b1;
        end else if ({1'b0, page} == e_next) begin
          new_ent = {1'b0, e_next + 7'd1, 2'b00};
        end else begin
          new_ent = {1'b0, e_next, e_cnt + 2'd1};
        end
      end
      default: begin
        new_ent = ent;
      end
    endcase
  end

  assign tbl_we    = (state == ST_CLEAR) | (state == ST_UPD);
  assign tbl_waddr = (state == ST_CLEAR) ? clr_idx : blk;

  nfc_block_table #(
    .AW (BLK_W),
    .DW (nfc_pkg::E_W)
  ) u_table (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_we     (tbl_we),
    .i_waddr  (tbl_waddr),
    .i_wdata  ((state == ST_CLEAR) ? nfc_pkg::E_W'(0) : new_ent),
    .i_raddr  (i_block),
    .o_rdata  (tbl_rdata)
  );

  // Bad block count and good block floor warning.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bad_count <= 13'h0000;
    end else if (state == ST_UPD && new_ent[nfc_pkg::E_BAD] && !ent[nfc_pkg::E_BAD]) begin
      o_bad_count <= o_bad_count + 13'h0001;
    end
  end
  assign o_good_low = (13'(nfc_pkg::N_BLOCKS) - o_bad_count) < 13'(nfc_pkg::MIN_GOOD);

  // Read data out, with a marker at each ECC codeword boundary.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data      <= 8'h00;
      o_rd_valid     <= 1'b0;
      o_ecc_unit_end <= 1'b0;
    end else begin
      o_rd_valid     <= (state == ST_RDAT) & cyc_done;
      o_ecc_unit_end <= (state == ST_RDAT) & cyc_done
                        & (cnt[8:0] == 9'(nfc_pkg::ECC_UNIT - 1));
      if (state == ST_RDAT && cyc_done) begin
        o_rd_data <= dq_s;
      end
    end
  end

  // Chip select and write protect; protection lifts only for program and erase.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ce_n <= 1'b1;
      o_wp_n <= 1'b0;
    end else begin
      o_ce_n <= state inside {ST_IDLE, ST_CLEAR, ST_CHK, ST_FIN};
      o_wp_n <= (state != ST_IDLE) & (state != ST_FIN)
                & (op == nfc_pkg::OP_PROG || op == nfc_pkg::OP_ERASE);
    end
  end

  assign o_cmd_ready = (state == ST_IDLE);
  assign o_done      = (state == ST_FIN);
  assign o_wr_ready  = (state == ST_WDAT) & ~cyc_act;

endmodule
`default_nettype wire

// *** rtl/nfc_pkg.sv ***
// Constants, command codes and operation codes for the host NAND flash controller.
// Operation
// - Reset during program: both pages unreliable.
// - During power-up busy, only reset or status.
// - Host sends only defined command codes.
// - While busy, only status reads and reset.
// - After data input, only program-family commands.
// - Pages programmed in ascending order per block.
// - Shared busy line: status read per device.
// - At most four partial programs per page.
// - Scan one column; all zeros means bad.
// - Never erase a block known bad.
// - Read status after program or erase.
// - Program failure: relocate data, table bad block; the code tables the block and raises o_fail but moves no data.
// - Correct eight bits per 512-byte unit; the code corrects nothing and only flags each unit end on o_ecc_unit_end.
// - Tolerate good blocks between minimum and total.
package nfc_pkg;

  // Command codes of the device command set.
  localparam logic [7:0] CMD_READ1   = 8'h00;
  localparam logic [7:0] CMD_READ2   = 8'h30;
  localparam logic [7:0] CMD_DATAIN  = 8'h80;
  localparam logic [7:0] CMD_PROG    = 8'h10;
  localparam logic [7:0] CMD_ERASE1  = 8'h60;
  localparam logic [7:0] CMD_ERASE2  = 8'hD0;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_RESET   = 8'hFF;

  // Status byte bit positions.
  localparam int ST_FAIL = 0;
  localparam int ST_RDY  = 6;
  localparam int ST_WP   = 7;

  // Bad block marker value seen by the scan.
  localparam logic [7:0] BB_MARK = 8'h00;

  // Geometry and limits.
  localparam int N_BLOCKS     = 4096;
  localparam int MIN_GOOD     = 4016;
  localparam int PAGES        = 64;
  localparam int MAX_PARTIAL  = 4;
  localparam int ECC_UNIT     = 512;
  localparam int ADDR_LAST    = 4;
  localparam int ROW_FIRST    = 2;

  // Block table entry layout.
  localparam int E_W        = 10;
  localparam int E_BAD      = 9;
  localparam int E_NEXT_LSB = 2;
  localparam int E_CNT_LSB  = 0;

  // Strobe phase time and its cycle count at the 125 MHz clock.
  localparam int T_PHASE_NS = 40;
  localparam int CLK_MHZ    = 125;
  localparam int PH_CYC     = (T_PHASE_NS * CLK_MHZ + 999) / 1000;

  // Bus cycle kinds.
  localparam logic [1:0] K_CMD  = 2'h0;
  localparam logic [1:0] K_ADDR = 2'h1;
  localparam logic [1:0] K_WR   = 2'h2;
  localparam logic [1:0] K_RD   = 2'h3;

  // User operations.
  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_PROG   = 3'b001,
    OP_ERASE  = 3'b010,
    OP_STATUS = 3'b011,
    OP_RESET  = 3'b100,
    OP_SCAN   = 3'b101
  } nfc_op_t;

endpackage

// *** rtl/nfc_block_table.sv ***
// Per-block table memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module nfc_block_table #(
  parameter int AW = 12,
  parameter int DW = 10
) (
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [2**AW];

  // Write port; contents are cleared by the controller after reset.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule
`default_nettype wire

// *** testbench/nfc_host_props.sv ***
// Checker for the pin sequencing of the host flash controller.
`timescale 1ns/1ps
`default_nettype none
module nfc_host_props (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        o_cmd_ready,
  input wire logic        o_done,
  input wire logic        o_refused,
  input wire logic        o_rd_valid,
  input wire logic        o_ecc_unit_end,
  input wire logic [12:0] o_bad_count,
  input wire logic        o_good_low,
  input wire logic        o_ce_n,
  input wire logic        o_cle,
  input wire logic        o_we_n,
  input wire logic        o_re_n,
  input wire logic        o_wp_n,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe,
  input wire logic        i_ready_busy_line
);
  logic       we_q;
  logic [7:0] last_cmd;
  logic       cmd_lat;

  // A command byte counts as latched one cycle after the write strobe rises.
  assign cmd_lat = o_we_n && !we_q && o_cle;

  // Keeps the previous write strobe and the last command byte latched.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      we_q     <= 1'b1;
      last_cmd <= 8'h00;
    end else begin
      we_q <= o_we_n;
      if (cmd_lat) begin
        last_cmd <= o_dq;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_prog_go;
    cmd_lat && (o_dq == 8'h10 || o_dq == 8'hD0);
  endsequence
  sequence s_status_cmd;
    cmd_lat && o_dq == 8'h70;
  endsequence

  chk_cmd_known: assert property (
    cmd_lat |-> o_dq inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70, 8'hFF})
    else $error("Unknown command byte latched");
  chk_busy_cmd: assert property (
    cmd_lat && !$past(i_ready_busy_line) |-> o_dq inside {8'h70, 8'h71, 8'hFF})
    else $error("Command sent while device busy");
  chk_after_datain: assert property (
    cmd_lat && last_cmd == 8'h80 |-> o_dq inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF})
    else $error("Illegal command after data input");
  chk_status_follows: assert property (
    s_prog_go |-> ##[1:60] s_status_cmd)
    else $error("No status read after program or erase");
  chk_wp_idle: assert property (
    o_cmd_ready |-> !o_wp_n && o_ce_n)
    else $error("Protect released or chip selected while idle");
  chk_refuse_quiet: assert property (
    o_done && o_refused |-> o_ce_n && $past(o_ce_n) && $past(o_ce_n, 3))
    else $error("Refused request touched the pins");
  chk_ecc_mark: assert property (
    o_ecc_unit_end |-> o_rd_valid)
    else $error("Codeword mark without read byte");
  chk_good_low: assert property (
    o_good_low == (o_bad_count > 13'h0050))
    else $error("Good block warning wrong");
  chk_done_ready: assert property (
    o_done |=> o_cmd_ready)
    else $error("Not ready after done");
  chk_read_lines: assert property (
    !o_re_n |-> !o_dq_oe && o_we_n)
    else $error("Data pins driven during read strobe");
endmodule
`default_nettype wire

// *** testbench/nfc_flash_model.sv ***
// Behavioural model of the flash device on the far side of the host.
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter int BAD_BLK  = 5,
  parameter int FAIL_BLK = 7
) (
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_dq,
  output logic      [7:0] o_dq,
  output logic            o_pull_low
);
  logic [7:0]  adr [0:4];
  logic [17:0] row;
  logic [12:0] col = 13'h0000;
  logic [7:0]  data;
  logic        rdy;
  logic        stat = 1'b0;
  logic        pgm = 1'b0;
  logic        fail = 1'b0;
  int          nad = 0;
  int          busy = 200;

  // Address decode, page data with a marked bad block, and open-drain busy.
  assign row = {adr[4][1:0], adr[3], adr[2]};
  assign data = (row[17:6] == BAD_BLK) ? 8'h00 : (col[7:0] ^ row[7:0]);
  assign rdy = (busy == 0);
  assign o_pull_low = !rdy;

  // Busy time runs down in steps of 10 ns.
  initial begin
    o_dq = 8'h5A;
    for (int k = 0; k < 5; k++) begin
      adr[k] = 8'h00;
    end
  end
  always #10 if (busy > 0) busy = busy - 1;

  // Protect falling after power-up cancels any running program or erase.
  always @(negedge i_wp_n) if (busy > 0 && $time > 8) begin
    busy = 0;
    fail = 1'b1;
  end

  // Latches commands and address bytes on the write strobe; a program data byte only advances the column.
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      if (pgm && !(i_dq inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF})) pgm = 1'b0;
      case (i_dq)
        8'hFF: begin busy = 10; stat = 1'b0; pgm = 1'b0; end
        8'h70: stat = 1'b1;
        8'h00: begin stat = 1'b0; nad = 0; end
        8'h30: busy = 100;
        8'h80: begin pgm = 1'b1; nad = 0; end
        8'h10: if (pgm) begin busy = 300; fail = (row[17:6] == FAIL_BLK); pgm = 1'b0; end
        8'h60: nad = 2;
        8'hD0: begin busy = 200; fail = 1'b0; end
        default: ;
      endcase
    end else if (!i_ce_n && i_ale) begin
      if (nad < 5) adr[nad] = i_dq;
      nad = nad + 1;
      col = {adr[1][4:0], adr[0]};
    end else if (!i_ce_n) col = col + 1;
  end

  // Read strobe shows status or data; after it the pins no longer hold the byte.
  always @(negedge i_re_n) if (!i_ce_n) o_dq = stat ? {i_wp_n, rdy, rdy, 4'h0, fail} : data;
  always @(posedge i_re_n) begin
    if (!stat) col = col + 1;
    #2 o_dq = ~o_dq;
  end
endmodule
`default_nettype wire

// *** testbench/nfc_host_bench.sv ***
// Top testbench: host controller against the flash device model.
`timescale 1ns/1ps
`default_nettype none
module nfc_host_bench;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [11:0] blk = 12'h000;
  logic [5:0]  pg = 6'h00;
  logic [12:0] cl = 13'h0000;
  logic [12:0] ln = 13'h0001;
  logic        abort = 1'b0;
  logic        wr_valid = 1'b0;
  logic        done, refused, fail_o, rd_valid, ce_n, cle, ale, we_n, re_n, wp_n, dq_oe;
  logic        m_low, rb;
  logic [7:0]  status, rd_data, h_dq, m_dq, dq;
  logic [12:0] bad_cnt;
  logic [7:0]  rd_q [$];
  int          fails = 0;
  int          n_compared = 0;

  // Shared data pins and the pulled-up ready line.
  assign dq = dq_oe ? h_dq : m_dq;
  assign rb = !m_low;
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);

  nfc_host DUT (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_block(blk), .i_page(pg), .i_col(cl), .i_len(ln), .i_abort(abort),
    .o_cmd_ready(), .o_done(done), .o_refused(refused), .o_fail(fail_o),
    .o_status(status), .i_wr_data(8'hA5), .i_wr_valid(wr_valid), .o_wr_ready(),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_ecc_unit_end(), .o_bad_count(bad_cnt),
    .o_good_low(), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n),
    .o_wp_n(wp_n), .i_dq(dq), .o_dq(h_dq), .o_dq_oe(dq_oe), .i_ready_busy_line(rb)
  );
  nfc_flash_model u_mdl (
    .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_wp_n(wp_n), .i_dq(dq), .o_dq(m_dq), .o_pull_low(m_low)
  );

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Waits a bounded time for the end-of-operation pulse.
  task automatic wait_done();
    int n;
    n = 0;
    do begin @(negedge i_clk); n++; end while (done !== 1'b1 && n < 20000);
    if (done !== 1'b1) begin
      fails++;
      $display("BAD %0t: operation never finished", $time);
      give_verdict();
    end
  endtask

  // Issues one request and waits for it to finish.
  task automatic run_op(input logic [2:0] op, input logic [11:0] b, input logic [5:0] p,
                        input logic [12:0] c, input logic [12:0] l, input logic ab);
    rd_q.delete();
    @(posedge i_clk);
    #1;
    cmd_op = op; blk = b; pg = p; cl = c; ln = l; abort = ab;
    cmd_valid = 1'b1;
    wr_valid = 1'b1;
    @(posedge i_clk);
    #1 cmd_valid = 1'b0;
    wait_done();
    @(posedge i_clk);
    #1 wr_valid = 1'b0;
    abort = 1'b0;
  endtask

  task automatic sc_status_read();
    run_op(3'd3, 12'h000, 6'h00, 13'h0000, 13'h0001, 1'b0);
    chk(13'(status), 13'h0060);
    run_op(3'd0, 12'h003, 6'h01, 13'h000A, 13'h0003, 1'b0);
    chk(13'(rd_q.size()), 13'h0003);
    for (int i = 0; i < 3; i++) chk(13'(rd_q[i]), 13'(8'hC1 ^ (8'h0A + i)));
  endtask

  task automatic sc_scan();
    run_op(3'd5, 12'h003, 6'h00, 13'h0000, 13'h0001, 1'b0);
    chk(13'(fail_o), 13'h0000);
    run_op(3'd5, 12'h005, 6'h00, 13'h0000, 13'h0001, 1'b0);
    chk(13'(fail_o), 13'h0001);
    chk(bad_cnt, 13'h0001);
    run_op(3'd2, 12'h005, 6'h00, 13'h0000, 13'h0001, 1'b0);
    chk(13'(refused), 13'h0001);
  endtask

  task automatic sc_prog();
    run_op(3'd1, 12'h002, 6'h00, 13'h0000, 13'h0002, 1'b0);
    chk({11'h000, refused, fail_o}, 13'h0000);
    run_op(3'd1, 12'h002, 6'h02, 13'h0000, 13'h0002, 1'b0);
    chk(13'(refused), 13'h0001);
    for (int i = 0; i < 4; i++) begin
      run_op(3'd1, 12'h002, 6'h00, 13'h0010, 13'h0002, 1'b0);
      chk(13'(refused), 13'((i == 3) ? 1 : 0));
    end
    run_op(3'd2, 12'h003, 6'h00, 13'h0000, 13'h0001, 1'b0);
    chk({11'h000, refused, fail_o}, 13'h0000);
  endtask

  task automatic sc_faults();
    run_op(3'd1, 12'h007, 6'h00, 13'h0000, 13'h0002, 1'b0);
    chk(13'(fail_o), 13'h0001);
    chk(bad_cnt, 13'h0002);
    run_op(3'd1, 12'h009, 6'h00, 13'h0000, 13'h0002, 1'b1);
    chk(13'(fail_o), 13'h0001);
    chk(bad_cnt, 13'h0003);
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    wait_done();
    chk(13'(status[6]), 13'h0001);
    sc_status_read();
    sc_scan();
    sc_prog();
    sc_faults();
    give_verdict();
  end
endmodule

bind nfc_host nfc_host_props u_props (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
  .o_refused(o_refused), .o_rd_valid(o_rd_valid), .o_ecc_unit_end(o_ecc_unit_end),
  .o_bad_count(o_bad_count), .o_good_low(o_good_low), .o_ce_n(o_ce_n), .o_cle(o_cle),
  .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
  .i_ready_busy_line(i_ready_busy_line)
);
`default_nettype wire
